// [src/sfr_pkg.sv]
// Shared constants, opcodes and state types for the flash reset controller.
package sfr_pkg;
  localparam int CLK_NS        = 50;
  localparam int SCK_PERIOD_NS = 400;
  localparam int T_RP_NS       = 200;
  localparam int T_RH_NS       = 150;
  localparam int T_RS_NS       = 50;
  localparam int T_CS_NS       = 50;
  localparam int T_RPH_US      = 100;
  localparam int T_PU_US       = 300;
  localparam int T_SWR_US      = 100;

  // Least times round up to whole clock cycles, never below one.
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [15:0] T_RP_CYC   = 16'(cyc_up(T_RP_NS));
  localparam logic [15:0] T_RH_CYC   = 16'(cyc_up(T_RH_NS));
  localparam logic [15:0] T_RS_CYC   = 16'(cyc_up(T_RS_NS));
  localparam logic [15:0] T_CS_CYC   = 16'(cyc_up(T_CS_NS));
  localparam logic [15:0] T_RPH_CYC  = 16'(cyc_up(T_RPH_US * 1000));
  localparam logic [15:0] T_SWR_CYC  = 16'(cyc_up(T_SWR_US * 1000));
  localparam logic [15:0] PU_CYCLES  = 16'(cyc_up(T_PU_US * 1000));
  localparam logic [15:0] SCK_HALF   = 16'(SCK_PERIOD_NS / 2 / CLK_NS);
  localparam logic [15:0] HOST_GAP   = 16'(cyc_up(T_CS_NS) + 3);
  localparam logic [15:0] HOST_RPLOW = 16'(cyc_up(T_RP_NS) + 3);
  localparam logic [2:0]  LAST_BIT   = 3'h7;

  localparam logic [7:0] OP_DEEP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_RESUME          = 8'hAB;
  localparam logic [7:0] OP_SOFT_RST_ENABLE = 8'h66;
  localparam logic [7:0] OP_SOFT_RST        = 8'h99;

  typedef enum logic [5:0] {
    D_POR     = 6'b000001,
    D_STANDBY = 6'b000010,
    D_ACTIVE  = 6'b000100,
    D_DPD     = 6'b001000,
    D_WARM    = 6'b010000,
    D_SWRST   = 6'b100000
  } sfr_dev_state_type;

  typedef enum logic [5:0] {
    H_PWRUP = 6'b000001,
    H_IDLE  = 6'b000010,
    H_SHIFT = 6'b000100,
    H_CSHI  = 6'b001000,
    H_RSTLO = 6'b010000,
    H_RSTHI = 6'b100000
  } sfr_host_state_type;
endpackage

// [src/sfr_link_if.sv]
// Serial link between the flash reset controller and its host.
`timescale 1ns/100ps
interface sfr_link_if;
  logic sck;
  logic csN;
  logic si;
  logic so;
  logic soOe;
  logic rstPinN;
  logic io3Host;
  logic io3HostOe;
  logic io3Dev;
  logic io3DevOe;
  logic io3;

  // Line 3 has a pull-up, so it reads high when nobody drives it.
  assign io3 = io3DevOe ? io3Dev : (io3HostOe ? io3Host : 1'b1);

  modport dev (input sck, csN, si, rstPinN, io3,
               output so, soOe, io3Dev, io3DevOe);
  modport host (output sck, csN, si, rstPinN, io3Host, io3HostOe,
                input so, soOe, io3);
endinterface

// [src/sfr_device.sv]
// Flash end: power modes, command-driven deep power-down and resets.
// What this block does
// - Active while selected or busy, else standby.
// - Opcode B9h enters deep power-down.
// - Deep power-down obeys only resume or reset.
// - Host reissues operations cut by reset.
// - Hardware reset ignored during software reset.
// - Host stays deselected through power-up interval.
// - Reset inputs ignored during power-on reset.
// - Reset held low keeps device in reset.
// - Reset input high over setup time first.
// - Line 3 resets after select-high time or non-quad.
// - Long low pulse causes timed warm reset.
// - Line 3 ignored early; data while selected.
// - Failed power-on turns pin reset into cold.
// - Opcodes 66h then 99h perform software reset.
// - Cleared enable bit disables line 3 reset.
// - Reset aborts work, floats outputs, blocks commands.
// - Device drives line 3 high after quad reads.
// - Host drives line 3 high after quad writes.
// - Host raises select during reset, waits hold.
// - Host pulse plus hold covers warm duration.
`timescale 1ns/100ps
module sfr_device #(
  parameter logic [15:0] PuCycles = sfr_pkg::PU_CYCLES
) (
  input  wire logic                       core_clk,      // 20 MHz clock
  input  wire logic                       resetn,        // Sync reset
  sfr_link_if.dev                         link,          // Serial link
  input  wire logic                       busy,          // Work pending
  input  wire logic                       quadEnable,    // Quad enable bit
  input  wire logic                       quadCmdMode,   // Quad-command bit
  input  wire logic                       io3ResetEnable, // Line 3 reset on
  input  wire logic                       porFault,      // Power-on failed
  input  wire logic                       quadDataOut,   // Quad read running
  input  wire logic                       soData,        // Serial out data
  input  wire logic                       soEnable,      // Serial out wanted
  output sfr_pkg::sfr_dev_state_type      devState,      // Power state
  output logic                            coreRstN,      // Core reset, low
  output logic                            opValid,       // Opcode pulse
  output logic [7:0]                      opcode         // Accepted opcode
);
  import sfr_pkg::*;

  sfr_dev_state_type state_q;
  sfr_dev_state_type state_d;
  logic [4:0]  sync1_q;
  logic [4:0]  sync2_q;
  logic        sckD_q;
  logic        csD_q;
  logic [7:0]  shift_q;
  logic [2:0]  bitCnt_q;
  logic [15:0] csHighCnt_q;
  logic [15:0] highCnt_q;
  logic [15:0] lowCnt_q;
  logic [15:0] tmr_q;
  logic        pendDpd_q;
  logic        pendRes_q;
  logic        pendSw_q;
  logic        swArm_q;
  logic        quadRd_q;
  logic        opValid_q;
  logic [7:0]  opcode_q;
  logic        coreRstN_q;
  logic        io3Oe_q;
  logic        soOe_q;
  logic        so_q;

  wire logic       sckS     = sync2_q[4];
  wire logic       csS      = sync2_q[3];
  wire logic       siS      = sync2_q[2];
  wire logic       io3S     = sync2_q[1];
  wire logic       rstS     = sync2_q[0];
  wire logic       sckRise  = sckS & ~sckD_q;
  wire logic       csRise   = csS & ~csD_q;
  wire logic [7:0] newByte  = {shift_q[6:0], siS};
  wire logic       byteDone = sckRise & ~csS & (bitCnt_q == LAST_BIT);
  wire logic       inReset  = (state_q == D_POR) | (state_q == D_WARM) |
                              (state_q == D_SWRST);
  wire logic       inDpd    = state_q == D_DPD;
  // Only resume gets through in deep power-down.
  wire logic       cmdOk    = ~inReset &
                              (~inDpd | (newByte == OP_RESUME));
  wire logic       accept   = byteDone & cmdOk;
  wire logic       csLong   = csS & (csHighCnt_q == T_CS_CYC);
  wire logic       quadOn   = quadEnable & quadCmdMode;
  // Line 3 counts as reset only when enabled and not serving as data.
  wire logic       io3Elig  = io3ResetEnable &
                              (csLong | ~quadOn);
  wire logic       rstLow   = ~rstS | (io3Elig & ~io3S);
  wire logic       armed    = highCnt_q == T_RS_CYC;
  // Pulses shorter than the minimum width never fire.
  wire logic       hwTrig   = rstLow & armed & (lowCnt_q == T_RP_CYC - 1'b1)
                              & ~inReset;
  wire logic       tmrDone  = ((state_q == D_POR) & (tmr_q >= PuCycles)) |
                              ((state_q == D_WARM) & (tmr_q >= T_RPH_CYC)) |
                              ((state_q == D_SWRST) & (tmr_q >= T_SWR_CYC));
  wire logic       io3Drive = quadRd_q & csS & ~csLong;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      D_POR, D_WARM:
        if (tmrDone & ~rstLow) state_d = D_STANDBY;
      D_SWRST:
        if (tmrDone) state_d = D_STANDBY;
      D_DPD:
        if (csRise & pendRes_q) state_d = D_STANDBY;
      D_STANDBY, D_ACTIVE:
        if (csRise & pendDpd_q) state_d = D_DPD;
        else if (csRise & pendSw_q) state_d = D_SWRST;
        else if (~csS | busy) state_d = D_ACTIVE;
        else state_d = D_STANDBY;
      default:
        state_d = D_POR;
    endcase
    if (hwTrig)
      state_d = porFault ? D_POR : D_WARM;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      sync1_q <= 5'h1F;
      sync2_q <= 5'h1F;
      sckD_q  <= 1'b1;
      csD_q   <= 1'b1;
    end
    else
    begin
      sync1_q <= {link.sck, link.csN, link.si, link.io3, link.rstPinN};
      sync2_q <= sync1_q;
      sckD_q  <= sckS;
      csD_q   <= csS;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_q <= D_POR;
      tmr_q   <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      tmr_q   <= (state_d != state_q) ? 16'h0000 :
                 (tmr_q == 16'hFFFF) ? tmr_q : tmr_q + 16'h0001;
    end
  end

  // Low-pulse width and prior high time are measured here.
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      csHighCnt_q <= 16'h0000;
      highCnt_q   <= 16'h0000;
      lowCnt_q    <= 16'h0000;
    end
    else
    begin
      csHighCnt_q <= ~csS ? 16'h0000 :
                     csLong ? csHighCnt_q : csHighCnt_q + 16'h0001;
      highCnt_q   <= (rstLow & ~armed) | hwTrig ? 16'h0000 :
                     (~rstLow & ~armed) ? highCnt_q + 16'h0001 : highCnt_q;
      lowCnt_q    <= (rstLow & armed & ~hwTrig) ? lowCnt_q + 16'h0001
                     : 16'h0000;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn || inReset)
    begin
      shift_q   <= 8'h00;
      bitCnt_q  <= 3'h0;
      pendDpd_q <= 1'b0;
      pendRes_q <= 1'b0;
      pendSw_q  <= 1'b0;
      swArm_q   <= 1'b0;
      quadRd_q  <= 1'b0;
    end
    else
    begin
      if (csS)
        bitCnt_q <= 3'h0;
      else if (sckRise)
      begin
        shift_q  <= newByte;
        bitCnt_q <= bitCnt_q + 3'h1;
      end
      // A quad read is noted while selected, so line 3 can be driven high
      // from the cycle after select is seen to rise.
      if (~csS)
        quadRd_q <= quadDataOut & quadOn;
      if (csRise)
      begin
        pendDpd_q <= 1'b0;
        pendRes_q <= 1'b0;
        pendSw_q  <= 1'b0;
      end
      else if (accept)
      begin
        pendDpd_q <= ~inDpd & (newByte == OP_DEEP_POWER_DOWN);
        pendRes_q <= inDpd & (newByte == OP_RESUME);
        pendSw_q  <= swArm_q & (newByte == OP_SOFT_RST);
        swArm_q   <= newByte == OP_SOFT_RST_ENABLE;
      end
    end
  end

  // Outputs float and commands are blocked while in reset.
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      opValid_q  <= 1'b0;
      opcode_q   <= 8'h00;
      coreRstN_q <= 1'b0;
      io3Oe_q    <= 1'b0;
      soOe_q     <= 1'b0;
      so_q       <= 1'b0;
    end
    else
    begin
      opValid_q  <= accept;
      opcode_q   <= accept ? newByte : opcode_q;
      coreRstN_q <= ~inReset & ~hwTrig;
      io3Oe_q    <= io3Drive & ~inReset;
      soOe_q     <= soEnable & ~csS & (state_q == D_ACTIVE);
      so_q       <= soData;
    end
  end

  assign link.io3Dev   = 1'b1;
  assign link.io3DevOe = io3Oe_q;
  assign link.soOe     = soOe_q;
  assign link.so       = so_q;
  assign devState      = state_q;
  assign coreRstN      = coreRstN_q;
  assign opValid       = opValid_q;
  assign opcode        = opcode_q;
endmodule

// [src/sfr_host.sv]
// Host end: sends opcodes, times power-up and drives hardware reset pulses.
`timescale 1ns/100ps
module sfr_host #(
  parameter logic [15:0] PuCycles = sfr_pkg::PU_CYCLES
) (
  input  wire logic                   core_clk,  // 20 MHz clock
  input  wire logic                   resetn,    // Sync reset
  sfr_link_if.host                    link,      // Serial link
  input  wire logic                   cmdValid,  // Send an opcode
  input  wire logic [7:0]             cmdByte,   // Opcode to send
  input  wire logic                   cmdQuadWr, // Opcode wrote quad data
  input  wire logic                   rstReq,    // Request pin reset
  output logic                        cmdReady,  // Idle, may take request
  output logic                        reissue,   // Reset done pulse
  output sfr_pkg::sfr_host_state_type hostState  // Host state
);
  import sfr_pkg::*;

  sfr_host_state_type state_q;
  sfr_host_state_type state_d;
  logic [15:0] tmr_q;
  logic [15:0] div_q;
  logic [7:0]  shift_q;
  logic [2:0]  bit_q;
  logic        sck_q;
  logic        csN_q;
  logic        rstN_q;
  logic        quadWr_q;
  logic        ready_q;
  logic        reissue_q;

  wire logic halfDone = div_q == SCK_HALF - 1'b1;
  wire logic lastFall = halfDone & sck_q & (bit_q == LAST_BIT);
  wire logic takeCmd  = (state_q == H_IDLE) & cmdValid & ~rstReq;
  wire logic takeRst  = (state_q == H_IDLE) & rstReq;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      // No select before the power-up interval ends.
      H_PWRUP: if (tmr_q >= PuCycles) state_d = H_IDLE;
      H_IDLE:  if (takeRst) state_d = H_RSTLO;
               else if (takeCmd) state_d = H_SHIFT;
      H_SHIFT: if (lastFall) state_d = H_CSHI;
      H_CSHI:  if (tmr_q >= HOST_GAP) state_d = H_IDLE;
      H_RSTLO: if (tmr_q >= HOST_RPLOW) state_d = H_RSTHI;
      // Hold alone covers the warm duration and the setup time.
      H_RSTHI: if (tmr_q >= T_RPH_CYC) state_d = H_IDLE;
      default: state_d = H_PWRUP;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_q <= H_PWRUP;
      tmr_q   <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      tmr_q   <= (state_d != state_q) ? 16'h0000 : tmr_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      div_q    <= 16'h0000;
      shift_q  <= 8'h00;
      bit_q    <= 3'h0;
      sck_q    <= 1'b0;
      quadWr_q <= 1'b0;
    end
    else if (takeCmd)
    begin
      div_q    <= 16'h0000;
      shift_q  <= cmdByte;
      bit_q    <= 3'h0;
      sck_q    <= 1'b0;
      quadWr_q <= cmdQuadWr;
    end
    else if (state_q == H_SHIFT)
    begin
      div_q <= halfDone ? 16'h0000 : div_q + 16'h0001;
      if (halfDone)
      begin
        sck_q <= ~sck_q;
        if (sck_q)
        begin
          shift_q <= {shift_q[6:0], 1'b0};
          bit_q   <= bit_q + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      csN_q     <= 1'b1;
      rstN_q    <= 1'b1;
      ready_q   <= 1'b0;
      reissue_q <= 1'b0;
    end
    else
    begin
      // Select stays high throughout a pin reset and its hold.
      csN_q     <= state_d != H_SHIFT;
      rstN_q    <= state_d != H_RSTLO;
      ready_q   <= state_d == H_IDLE;
      // Work cut by the reset must be issued again.
      reissue_q <= (state_q == H_RSTHI) & (state_d == H_IDLE);
    end
  end

  assign link.sck       = sck_q;
  assign link.csN       = csN_q;
  assign link.si        = shift_q[7];
  assign link.rstPinN   = rstN_q;
  assign link.io3Host   = 1'b1;
  assign link.io3HostOe = quadWr_q & (state_q == H_CSHI);
  assign cmdReady       = ready_q;
  assign reissue        = reissue_q;
  assign hostState      = state_q;
endmodule

// [bench/sfr_asserts.sv]
// Concurrent checks on the serial link between the two flash reset ends.
`timescale 1ns/100ps
module sfr_asserts #(
  parameter logic [15:0] PuCycles = 16'h0032
) (
  input wire logic core_clk,  // Clock
  input wire logic resetn,    // Sync reset, low
  input wire logic sck,       // Serial clock
  input wire logic csN,       // Select, low
  input wire logic soOe,      // Device data enable
  input wire logic rstPinN,   // Reset pin, low
  input wire logic io3Host,   // Host line 3 value
  input wire logic io3HostOe, // Host line 3 enable
  input wire logic io3Dev,    // Device line 3 value
  input wire logic io3DevOe   // Device line 3 enable
);
  logic [15:0] upCnt_q;

  // Counts cycles since reset release, saturating.
  always_ff @(posedge core_clk)
    if (!resetn)
      upCnt_q <= 16'h0000;
    else if (upCnt_q != 16'hFFFF)
      upCnt_q <= upCnt_q + 16'h0001;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  pwrup_desel_a: assert property (upCnt_q < PuCycles |-> csN && !sck)
    else $error("select low during power-up");
  pulse_width_a: assert property ($fell(rstPinN) |->
    !rstPinN [*8] ##1 rstPinN) else $error("reset pulse width wrong");
  rst_desel_a: assert property (!rstPinN |-> csN)
    else $error("select low while reset low");
  hold_desel_a: assert property ($rose(rstPinN) |-> csN [*3])
    else $error("select low inside reset hold");
  setup_high_a: assert property ($rose(rstPinN) |-> rstPinN [*2])
    else $error("reset pin high too briefly");
  float_out_a: assert property (!rstPinN [*8] |-> !soOe && !io3DevOe)
    else $error("outputs driven during reset");
  dev_io3_hi_a: assert property (io3DevOe |-> io3Dev && csN)
    else $error("device line 3 not driven high");
  host_io3_hi_a: assert property (io3HostOe && csN |-> io3Host)
    else $error("host line 3 low while deselected");
  no_fight_a: assert property (io3HostOe && io3DevOe |->
    io3Host == io3Dev) else $error("line 3 contention");
endmodule

// [bench/tb_serial_flash_reset_power_ctrl.sv]
// Testbench joining both ends of the flash reset controller.
`timescale 1ns/100ps
module tb_serial_flash_reset_power_ctrl;
  import sfr_pkg::*;
  localparam logic [15:0] PU_SIM = 16'h0032;
  localparam int          LIMIT  = 30000;
  logic core_clk, resetn, busy, quadEn, quadCmd, io3RstEn, porFault;
  logic quadOut, cmdValid, cmdQuadWr, rstReq, cmdReady, reissue;
  logic coreRstN, coreRstN2, opValid, soEn;
  logic [7:0] cmdByte, opcode;
  sfr_dev_state_type  devState, devState2;
  sfr_host_state_type hostState;
  int fail_count, checks, cycles, opCnt, reCnt, dvCnt;

  sfr_link_if link();
  sfr_link_if link2();
  sfr_device #(.PuCycles(PU_SIM)) i_sfr_device (.core_clk(core_clk),
    .resetn(resetn), .link(link.dev), .busy(busy), .quadEnable(quadEn),
    .quadCmdMode(quadCmd), .io3ResetEnable(io3RstEn), .porFault(porFault),
    .quadDataOut(quadOut), .soData(1'b0), .soEnable(soEn),
    .devState(devState), .coreRstN(coreRstN), .opValid(opValid),
    .opcode(opcode));
  sfr_device #(.PuCycles(PU_SIM)) i_sfr_device_b (.core_clk(core_clk),
    .resetn(resetn), .link(link2.dev), .busy(busy), .quadEnable(quadEn),
    .quadCmdMode(quadCmd), .io3ResetEnable(io3RstEn), .porFault(1'b0),
    .quadDataOut(1'b0), .soData(1'b0), .soEnable(1'b0),
    .devState(devState2), .coreRstN(coreRstN2), .opValid(), .opcode());
  sfr_host #(.PuCycles(PU_SIM)) i_sfr_host (.core_clk(core_clk),
    .resetn(resetn), .link(link.host), .cmdValid(cmdValid),
    .cmdByte(cmdByte), .cmdQuadWr(cmdQuadWr), .rstReq(rstReq),
    .cmdReady(cmdReady), .reissue(reissue), .hostState(hostState));
  sfr_asserts #(.PuCycles(PU_SIM)) i_sfr_asserts (.core_clk(core_clk),
    .resetn(resetn), .sck(link.sck), .csN(link.csN), .soOe(link.soOe),
    .rstPinN(link.rstPinN), .io3Host(link.io3Host),
    .io3HostOe(link.io3HostOe), .io3Dev(link.io3Dev),
    .io3DevOe(link.io3DevOe));

  always #25 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    if (opValid === 1'b1)
      opCnt <= opCnt + 1;
    if (reissue === 1'b1)
      reCnt <= reCnt + 1;
    if (link.io3DevOe === 1'b1)
      dvCnt <= dvCnt + 1;
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      fail_count++;
      conclude();
    end
  end

  task conclude();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  // Waits a bounded time for a power state of either device, then judges it.
  task waitDev(input bit two, input logic [5:0] s, input int n);
    int i;
    for (i = 0; i < n && (two ? devState2 : devState) !== s; i++)
      @(negedge core_clk);
    chk(two ? "devState2" : "devState", {2'b00, s},
        {2'b00, two ? devState2 : devState});
  endtask

  task waitReady();
    int i;
    for (i = 0; i < 2500 && cmdReady !== 1'b1; i++)
      @(negedge core_clk);
    if (cmdReady !== 1'b1)
    begin
      $display("unexpected cmdReady: expected 1, seen %b", cmdReady);
      fail_count++;
    end
  endtask

  task send(input logic [7:0] b);
    waitReady();
    cmdByte = b;
    cmdValid = 1'b1;
    @(negedge core_clk);
    cmdValid = 1'b0;
    @(negedge core_clk);
    waitReady();
    repeat (4) @(negedge core_clk);
  endtask

  task pinReset();
    waitReady();
    rstReq = 1'b1;
    @(negedge core_clk);
    rstReq = 1'b0;
  endtask

  task t_powerup();
    waitDev(1'b0, D_STANDBY, 200);
    chk("devState2", {2'b00, D_STANDBY}, {2'b00, devState2});
    $display("power-up test done");
  endtask

  task t_active();
    busy = 1'b1;
    send(8'h03);
    chk("devState", {2'b00, D_ACTIVE}, {2'b00, devState});
    busy = 1'b0;
    waitDev(1'b0, D_STANDBY, 10);
    $display("active test done");
  endtask

  task t_dpd();
    int o;
    o = opCnt;
    send(OP_DEEP_POWER_DOWN);
    chk("devState", {2'b00, D_DPD}, {2'b00, devState});
    send(OP_SOFT_RST_ENABLE);
    send(OP_SOFT_RST);
    chk("devState", {2'b00, D_DPD}, {2'b00, devState});
    send(OP_RESUME);
    chk("devState", {2'b00, D_STANDBY}, {2'b00, devState});
    chk("opCount", 8'(o + 2), 8'(opCnt));
    chk("opcode", OP_RESUME, opcode);
    $display("deep power-down test done");
  endtask

  task t_swrst();
    send(OP_SOFT_RST_ENABLE);
    send(OP_SOFT_RST);
    chk("devState", {2'b00, D_SWRST}, {2'b00, devState});
    chk("coreRstN", 8'h00, {7'h00, coreRstN});
    waitDev(1'b0, D_STANDBY, 2200);
    $display("soft reset test done");
  endtask

  task t_pinrst();
    int r;
    r = reCnt;
    soEn = 1'b1;
    pinReset();
    waitDev(1'b0, D_WARM, 20);
    chk("soOe", 8'h00, {7'h00, link.soOe});
    repeat (1950) @(negedge core_clk);
    chk("devState", {2'b00, D_WARM}, {2'b00, devState});
    waitDev(1'b0, D_STANDBY, 100);
    waitReady();
    @(negedge core_clk);
    chk("reissueCount", 8'(r + 1), 8'(reCnt));
    soEn = 1'b0;
    $display("pin reset test done");
  endtask

  task t_porfault();
    porFault = 1'b1;
    pinReset();
    waitDev(1'b0, D_POR, 20);
    porFault = 1'b0;
    waitDev(1'b0, D_STANDBY, 100);
    $display("failed power-on test done");
  endtask

  task t_quad();
    int d;
    d = dvCnt;
    quadEn = 1'b1;
    quadCmd = 1'b1;
    quadOut = 1'b1;
    cmdQuadWr = 1'b1;
    send(8'h6B);
    chk("io3", 8'h01, {7'h00, link.io3});
    chk("io3DevOeSeen", 8'h01, {7'h00, dvCnt != d});
    chk("devState", {2'b00, D_STANDBY}, {2'b00, devState});
    quadEn = 1'b0;
    quadCmd = 1'b0;
    quadOut = 1'b0;
    cmdQuadWr = 1'b0;
    $display("quad line 3 test done");
  endtask

  task t_line3();
    link2.rstPinN = 1'b0;
    repeat (2) @(negedge core_clk);
    link2.rstPinN = 1'b1;
    repeat (10) @(negedge core_clk);
    chk("devState2", {2'b00, D_STANDBY}, {2'b00, devState2});
    io3RstEn = 1'b0;
    link2.io3HostOe = 1'b1;
    link2.io3Host = 1'b0;
    repeat (20) @(negedge core_clk);
    chk("devState2", {2'b00, D_STANDBY}, {2'b00, devState2});
    link2.io3Host = 1'b1;
    repeat (5) @(negedge core_clk);
    io3RstEn = 1'b1;
    link2.io3Host = 1'b0;
    repeat (20) @(negedge core_clk);
    chk("devState2", {2'b00, D_WARM}, {2'b00, devState2});
    link2.io3HostOe = 1'b0;
    waitDev(1'b1, D_STANDBY, 2100);
    $display("line 3 reset test done");
  endtask

  initial
  begin
    {core_clk, resetn, busy, quadEn, quadCmd, porFault, quadOut} = 7'h00;
    soEn = 1'b0;
    {cmdValid, cmdQuadWr, rstReq, io3RstEn, cmdByte} = 12'h100;
    {fail_count, checks, cycles, opCnt, reCnt, dvCnt} = '0;
    {link2.sck, link2.si, link2.rstPinN, link2.io3HostOe} = 4'h0;
    link2.csN = 1'b1;
    link2.io3Host = 1'b1;
    repeat (6) @(negedge core_clk);
    resetn = 1'b1;
    repeat (20) @(negedge core_clk);
    link2.rstPinN = 1'b1;
    t_powerup();
    t_active();
    t_dpd();
    t_swrst();
    t_pinrst();
    t_porfault();
    t_quad();
    t_line3();
    conclude();
  end
endmodule
